// [ccfg_consts.vh]
`ifndef CCFG_CONSTS_VH
`define CCFG_CONSTS_VH
`define CCFG_PAGE_ADDR        8'h00
`define CCFG_ADC_LIMIT_ADDR   8'h0E
`define CCFG_DAC_LIMIT_ADDR   8'h0F
`define CCFG_SRC_CTRL_ADDR    8'h17
`define CCFG_SRC_RATIO_ADDR   8'h18
`define CCFG_DET_TIMING_ADDR  8'h19
`define CCFG_DET_OPT_ADDR     8'h1A
`define CCFG_CFG_PAGE         8'h00
`define CCFG_RESET_VALUE      8'h00
`define CCFG_LIMIT_WMASK      8'hF8
`define CCFG_SRC_CTRL_WMASK   8'hC0
`define CCFG_SRC_RATIO_WMASK  8'hFF
`define CCFG_DET_TIMING_WMASK 8'hFF
`define CCFG_DET_OPT_WMASK    8'h7E
`define CCFG_USE_CUSTOM_BIT   7
`define CCFG_MASK_HI          6
`define CCFG_MASK_LO          3
`define CCFG_PRESET_CODE_AUTO 3'h0
`define CCFG_RATIO_RSVD_A     3'h5
`define CCFG_RATIO_RSVD_B     3'h7
`define CCFG_TICK_RSVD        2'h3
`define CCFG_CLK_MHZ          50
`define CCFG_TICK_MS_MIN      1
`define CCFG_TICK_CYCLES      (`CCFG_TICK_MS_MIN * `CCFG_CLK_MHZ * 1000)
`endif

// [ccfg_regs.v]
`timescale 1ns/10ps
`default_nettype none
`include "ccfg_consts.vh"
module ccfg_regs (
  input  wire       clock,
  input  wire       rst,
  input  wire       wr_en,
  input  wire       rd_en,
  input  wire [7:0] addr,
  input  wire [7:0] wr_data,
  output reg  [7:0] rd_data,
  output wire [7:0] page_sel,
  output wire       adc_use_custom_ceiling,
  output wire [3:0] adc_custom_channel_mask,
  input  wire [3:0] adc_preset_ceiling,
  output wire [3:0] adc_channel_ceiling,
  output wire       dac_use_custom_ceiling,
  output wire [3:0] dac_custom_channel_mask,
  input  wire [3:0] dac_preset_ceiling,
  output wire [3:0] dac_channel_ceiling,
  output wire       rate_converter_on,
  output wire       rate_autodetect_off,
  output wire       main_rate_manual,
  output wire       main_rate_source,
  output wire [2:0] ratio_m_code,
  output wire [2:0] ratio_n_code,
  output wire       ratio_m_auto,
  output wire       ratio_n_auto,
  output wire       ratio_code_reserved,
  output wire [1:0] detect_pulse_rate,
  output wire       detect_pulse_high_time,
  output wire [1:0] phone_detect_tick_period,
  output wire       tick_period_reserved,
  output wire [7:0] headset_detect_options
);

  reg  [7:0] page_reg;
  reg  [7:0] adc_limit_reg;
  reg  [7:0] dac_limit_reg;
  reg  [7:0] src_ctrl_reg;
  reg  [7:0] src_ratio_reg;
  reg  [7:0] det_timing_reg;
  reg  [7:0] det_opt_reg;
  reg  [7:0] page_next;
  reg  [7:0] adc_limit_next;
  reg  [7:0] dac_limit_next;
  reg  [7:0] src_ctrl_next;
  reg  [7:0] src_ratio_next;
  reg  [7:0] det_timing_next;
  reg  [7:0] det_opt_next;
  reg  [7:0] rd_data_next;
  reg        ratio_m_reserved;
  reg        ratio_n_reserved;
  reg        tick_reserved;
  wire       cfg_page;
  wire       page_wr;
  wire       adc_limit_wr;
  wire       dac_limit_wr;
  wire       src_ctrl_wr;
  wire       src_ratio_wr;
  wire       det_timing_wr;
  wire       det_opt_wr;
  wire [7:0] adc_limit_view;
  wire [7:0] dac_limit_view;
  wire [7:0] src_ctrl_view;
  wire [7:0] src_ratio_view;
  wire [7:0] det_timing_view;
  wire [7:0] det_opt_view;

  // Paged map: only the configuration page reaches this slice
  assign cfg_page = (page_reg == `CCFG_CFG_PAGE);

  // Page register is visible on every page
  assign page_wr       = wr_en &
                         (addr == `CCFG_PAGE_ADDR);
  assign adc_limit_wr  = wr_en &
                         cfg_page &
                         (addr == `CCFG_ADC_LIMIT_ADDR);
  assign dac_limit_wr  = wr_en &
                         cfg_page &
                         (addr == `CCFG_DAC_LIMIT_ADDR);
  assign src_ctrl_wr   = wr_en &
                         cfg_page &
                         (addr == `CCFG_SRC_CTRL_ADDR);
  assign src_ratio_wr  = wr_en &
                         cfg_page &
                         (addr == `CCFG_SRC_RATIO_ADDR);
  assign det_timing_wr = wr_en &
                         cfg_page &
                         (addr == `CCFG_DET_TIMING_ADDR);
  assign det_opt_wr    = wr_en &
                         cfg_page &
                         (addr == `CCFG_DET_OPT_ADDR);

  // Reserved bits read back as zero, except in detection timing where they read back as written
  assign adc_limit_view  = adc_limit_reg & `CCFG_LIMIT_WMASK;
  assign dac_limit_view  = dac_limit_reg & `CCFG_LIMIT_WMASK;
  assign src_ctrl_view   = src_ctrl_reg & `CCFG_SRC_CTRL_WMASK;
  assign src_ratio_view  = src_ratio_reg & `CCFG_SRC_RATIO_WMASK;
  assign det_timing_view = det_timing_reg & `CCFG_DET_TIMING_WMASK;
  assign det_opt_view    = det_opt_reg & `CCFG_DET_OPT_WMASK;

  // Page select
  always @* begin
    if (page_wr) begin
      page_next = wr_data;
    end else begin
      page_next = page_reg;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      page_reg <= `CCFG_RESET_VALUE;
    end else begin
      page_reg <= page_next;
    end
  end

  // ADC ceiling select and custom mask
  always @* begin
    if (adc_limit_wr) begin
      // Read-only low bits never take write data
      adc_limit_next = wr_data & `CCFG_LIMIT_WMASK;
    end else begin
      adc_limit_next = adc_limit_reg;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      adc_limit_reg <= `CCFG_RESET_VALUE;
    end else begin
      adc_limit_reg <= adc_limit_next;
    end
  end

  // DAC ceiling select and custom mask
  always @* begin
    if (dac_limit_wr) begin
      // Read-only low bits never take write data
      dac_limit_next = wr_data & `CCFG_LIMIT_WMASK;
    end else begin
      dac_limit_next = dac_limit_reg;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      dac_limit_reg <= `CCFG_RESET_VALUE;
    end else begin
      dac_limit_reg <= dac_limit_next;
    end
  end

  // Rate converter enable and autodetect
  always @* begin
    if (src_ctrl_wr) begin
      // Only the two top bits are writable
      src_ctrl_next = wr_data & `CCFG_SRC_CTRL_WMASK;
    end else begin
      src_ctrl_next = src_ctrl_reg;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      src_ctrl_reg <= `CCFG_RESET_VALUE;
    end else begin
      src_ctrl_reg <= src_ctrl_next;
    end
  end

  // Main rate source and ratio codes
  always @* begin
    if (src_ratio_wr) begin
      src_ratio_next = wr_data & `CCFG_SRC_RATIO_WMASK;
    end else begin
      src_ratio_next = src_ratio_reg;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      src_ratio_reg <= `CCFG_RESET_VALUE;
    end else begin
      src_ratio_reg <= src_ratio_next;
    end
  end

  // Detection pulse timing; reserved bits are stored as written
  always @* begin
    if (det_timing_wr) begin
      det_timing_next = wr_data & `CCFG_DET_TIMING_WMASK;
    end else begin
      det_timing_next = det_timing_reg;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      det_timing_reg <= `CCFG_RESET_VALUE;
    end else begin
      det_timing_reg <= det_timing_next;
    end
  end

  // Detection options
  always @* begin
    if (det_opt_wr) begin
      // Both edge bits are masked so they always read zero
      det_opt_next = wr_data & `CCFG_DET_OPT_WMASK;
    end else begin
      det_opt_next = det_opt_reg;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      det_opt_reg <= `CCFG_RESET_VALUE;
    end else begin
      det_opt_reg <= det_opt_next;
    end
  end

  // Read data holds its last value until the next read
  always @* begin
    rd_data_next = rd_data;
    if (rd_en) begin
      if (addr == `CCFG_PAGE_ADDR) begin
        rd_data_next = page_reg;
      end else if (!cfg_page) begin
        rd_data_next = `CCFG_RESET_VALUE;
      end else begin
        case (addr)
          `CCFG_ADC_LIMIT_ADDR:  rd_data_next = adc_limit_view;
          `CCFG_DAC_LIMIT_ADDR:  rd_data_next = dac_limit_view;
          `CCFG_SRC_CTRL_ADDR:   rd_data_next = src_ctrl_view;
          `CCFG_SRC_RATIO_ADDR:  rd_data_next = src_ratio_view;
          `CCFG_DET_TIMING_ADDR: rd_data_next = det_timing_view;
          `CCFG_DET_OPT_ADDR:    rd_data_next = det_opt_view;
          default:               rd_data_next = `CCFG_RESET_VALUE;
        endcase
      end
    end
  end

  // Registered so the host sees a stable byte after the strobe
  always @(posedge clock) begin
    if (rst) begin
      rd_data <= `CCFG_RESET_VALUE;
    end else begin
      rd_data <= rd_data_next;
    end
  end

  assign page_sel = page_reg;

  assign adc_use_custom_ceiling  = adc_limit_reg[`CCFG_USE_CUSTOM_BIT];
  assign adc_custom_channel_mask =
    adc_limit_reg[`CCFG_MASK_HI:`CCFG_MASK_LO];

  assign dac_use_custom_ceiling  = dac_limit_reg[`CCFG_USE_CUSTOM_BIT];
  assign dac_custom_channel_mask =
    dac_limit_reg[`CCFG_MASK_HI:`CCFG_MASK_LO];

  // One mux per channel bit; all four channels share one select, adc_use_custom_ceiling or dac_use_custom_ceiling
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_ceiling
      assign adc_channel_ceiling[ch] = adc_use_custom_ceiling ?
        adc_custom_channel_mask[ch] : adc_preset_ceiling[ch];
      assign dac_channel_ceiling[ch] = dac_use_custom_ceiling ?
        dac_custom_channel_mask[ch] : dac_preset_ceiling[ch];
    end
  endgenerate

  assign rate_converter_on   = src_ctrl_reg[7];
  assign rate_autodetect_off = src_ctrl_reg[6];

  assign main_rate_manual = src_ratio_reg[7];
  // Source choice only matters once manual selection is on
  assign main_rate_source = main_rate_manual & src_ratio_reg[6];
  assign ratio_m_code     = src_ratio_reg[5:3];
  assign ratio_n_code     = src_ratio_reg[2:0];
  assign ratio_m_auto     = (ratio_m_code == `CCFG_PRESET_CODE_AUTO);
  assign ratio_n_auto     = (ratio_n_code == `CCFG_PRESET_CODE_AUTO);

  // Flag rather than reject: the host is trusted to avoid these codes
  always @* begin
    case (ratio_m_code)
      `CCFG_RATIO_RSVD_A: ratio_m_reserved = 1'b1;
      `CCFG_RATIO_RSVD_B: ratio_m_reserved = 1'b1;
      default:            ratio_m_reserved = 1'b0;
    endcase
  end

  always @* begin
    case (ratio_n_code)
      `CCFG_RATIO_RSVD_A: ratio_n_reserved = 1'b1;
      `CCFG_RATIO_RSVD_B: ratio_n_reserved = 1'b1;
      default:            ratio_n_reserved = 1'b0;
    endcase
  end

  assign ratio_code_reserved = ratio_m_reserved | ratio_n_reserved;

  assign detect_pulse_rate        = det_timing_reg[7:6];
  assign detect_pulse_high_time   = det_timing_reg[5];
  assign phone_detect_tick_period = det_timing_reg[2:1];

  // Code 3 is kept as written and only flagged
  always @* begin
    case (phone_detect_tick_period)
      `CCFG_TICK_RSVD: tick_reserved = 1'b1;
      default:         tick_reserved = 1'b0;
    endcase
  end

  assign tick_period_reserved = tick_reserved;

  assign headset_detect_options = det_opt_view;

endmodule
`default_nettype wire

// [ccfg_regs_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module ccfg_regs_chk (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] page_sel,
  input wire logic       adc_use_custom_ceiling,
  input wire logic [3:0] adc_custom_channel_mask,
  input wire logic [3:0] adc_preset_ceiling,
  input wire logic [3:0] adc_channel_ceiling,
  input wire logic       rate_converter_on,
  input wire logic       main_rate_manual,
  input wire logic       main_rate_source
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire       p0 = page_sel == 8'h00;
  wire       rd_on = rd_en && p0;
  wire [3:0] ceil = adc_use_custom_ceiling ? adc_custom_channel_mask
                                           : adc_preset_ceiling;
  wire [7:0] v0e = {adc_use_custom_ceiling, adc_custom_channel_mask, 3'h0};
  chk_adc_ceil_mux: assert property (adc_channel_ceiling == ceil)
    else $error("adc ceiling");
  chk_adc_mask_wr: assert property (wr_en && p0 && addr == 8'h0E |=>
    adc_custom_channel_mask == $past(wr_data[6:3])) else $error("mask");
  chk_src_on_wr: assert property (wr_en && p0 && addr == 8'h17 |=>
    rate_converter_on == $past(wr_data[7])) else $error("src on");
  chk_src_gate: assert property (!main_rate_manual |-> !main_rate_source)
    else $error("rate source");
  chk_ro_zero: assert property (rd_on && addr == 8'h17 |=>
    rd_data[5:0] == 6'h00) else $error("ro bits");
  chk_page_hold: assert property (wr_en && !p0 && addr != 8'h00 |=>
    $stable(rate_converter_on)) else $error("page write");
  chk_page_rd: assert property (rd_en && !p0 && addr != 8'h00 |=>
    rd_data == 8'h00) else $error("page read");
  chk_adc_rdback: assert property (rd_on && addr == 8'h0E |=>
    rd_data == $past(v0e)) else $error("readback");
endmodule
bind ccfg_regs ccfg_regs_chk i_ccfg_regs_chk (.*);
`default_nettype wire

// [tb_ccfg_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_ccfg_regs;
  logic clock = 0, rst = 1, wr_en = 0, rd_en = 0;
  logic [7:0] addr = 8'h00, wr_data = 8'h00;
  logic [3:0] adc_preset_ceiling = 4'h5, dac_preset_ceiling = 4'hA;
  wire [7:0] rd_data, page_sel, headset_detect_options;
  wire [3:0] adc_custom_channel_mask, adc_channel_ceiling;
  wire [3:0] dac_custom_channel_mask, dac_channel_ceiling;
  wire [2:0] ratio_m_code, ratio_n_code;
  wire [1:0] detect_pulse_rate, phone_detect_tick_period;
  wire adc_use_custom_ceiling, dac_use_custom_ceiling, ratio_m_auto;
  wire rate_converter_on, rate_autodetect_off, main_rate_manual;
  wire main_rate_source, ratio_n_auto, ratio_code_reserved;
  wire detect_pulse_high_time, tick_period_reserved;
  int fails = 0, compares = 0;
  ccfg_regs i_ccfg_regs (.*);
  always #10 clock = ~clock;
  task chk(input logic [7:0] s, e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Strobe drops one cycle later, at the next falling edge, so back-to-back calls never clash
  task wr(input logic [7:0] a, d);
    @(negedge clock) {addr, wr_data, wr_en} = {a, d, 1'b1};
    @(negedge clock) wr_en = 0;
  endtask
  task rd(input logic [7:0] a, e);
    @(negedge clock) {addr, rd_en} = {a, 1'b1};
    @(negedge clock) rd_en = 0;
    chk(rd_data, e);
  endtask
  task t_lim;
    wr(8'h0E, 8'h4F);
    chk(adc_channel_ceiling, 4'h5);
    wr(8'h0E, 8'hC8);
    chk(adc_channel_ceiling, 4'h9);
    rd(8'h0E, 8'hC8);
    wr(8'h0F, 8'h8F);
    chk(dac_channel_ceiling, 4'h1);
    wr(8'h0F, 8'h07);
    chk(dac_channel_ceiling, 4'hA);
    $display("limits done");
  endtask
  task t_cfg;
    rd(8'h17, 8'h00);
    wr(8'h17, 8'hFF);
    rd(8'h17, 8'hC0);
    chk({rate_converter_on, rate_autodetect_off}, 2'h3);
    wr(8'h18, 8'h40);
    chk(main_rate_source, 1'b0);
    wr(8'h18, 8'hED);
    chk({main_rate_source, ratio_code_reserved}, 2'h3);
    wr(8'h18, 8'hB2);
    chk({ratio_m_code, ratio_code_reserved, ratio_n_code}, 7'h62);
    wr(8'h18, 8'h00);
    chk({ratio_m_auto, ratio_n_auto}, 2'h3);
    wr(8'h19, 8'hE6);
    chk({detect_pulse_rate, phone_detect_tick_period}, 4'hF);
    chk({detect_pulse_high_time, tick_period_reserved}, 2'h3);
    rd(8'h19, 8'hE6);
    $display("config done");
  endtask
  task t_page;
    wr(8'h00, 8'h01);
    wr(8'h17, 8'h00);
    chk(rate_converter_on, 1'b1);
    rd(8'h17, 8'h00);
    wr(8'h00, 8'h00);
    rd(8'h20, 8'h00);
    rd(8'h17, 8'hC0);
    $display("paging done");
  endtask
  task t_rst;
    wr(8'h1A, 8'h7E);
    chk(headset_detect_options, 8'h7E);
    wr(8'h00, 8'h03);
    chk(page_sel, 8'h03);
    chk({adc_use_custom_ceiling, adc_custom_channel_mask}, 8'h19);
    chk({dac_use_custom_ceiling, dac_custom_channel_mask}, 8'h00);
    @(negedge clock) rst = 1;
    @(negedge clock) rst = 0;
    chk(page_sel, 8'h00);
    chk(headset_detect_options, 8'h00);
    chk(rd_data, 8'h00);
    chk({adc_use_custom_ceiling, adc_channel_ceiling}, 8'h05);
    chk({main_rate_manual, rate_converter_on, detect_pulse_rate}, 8'h00);
    wr(8'h18, 8'h80);
    chk(main_rate_manual, 1'b1);
    $display("reset done");
  endtask
  task print_verdict;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clock);
    rst = 0;
    t_lim;
    t_cfg;
    t_page;
    t_rst;
    print_verdict;
  end
endmodule
`default_nettype wire
